// File: inc/eir_map.svh
// Register indices, fields, resets and bus codes of the event router.
// Assumes a byte address of four times the register index.
`ifndef EIR_MAP_SVH
`define EIR_MAP_SVH

`define EIR_IDX_SM_HI_ROUTE 8'h10
`define EIR_IDX_CLS_ROUTE 8'h11
`define EIR_IDX_EMB_FLAGS 8'h12
`define EIR_IDX_SM_LO_FLAGS 8'h13
`define EIR_IDX_SM_HI_FLAGS 8'h14
`define EIR_IDX_CLS_FLAGS 8'h15
`define EIR_IDX_PAGE_CTRL 8'h17
`define EIR_IDX_PIN_B_CFG 8'h5F
`define EIR_IDX_SM_LO_ROUTE 8'h60
`define EIR_IDX_IRQ_STATUS 8'h61
`define EIR_IDX_IRQ_MASK 8'h62

`define EIR_LATCH_MODE_BIT 7
`define EIR_ROUTE_MASTER_BIT 1
`define EIR_EMB_LC_BIT 7
`define EIR_EMB_SIGMOT_BIT 5
`define EIR_EMB_TILT_BIT 4
`define EIR_EMB_STEP_BIT 3
`define EIR_EMB_VALID_MASK 8'hB8
`define EIR_ALL_VALID_MASK 8'hFF

`define EIR_IRQ_PIN_RISE_BIT 0
`define EIR_IRQ_BUS_ERR_BIT 1
`define EIR_IRQ_WIDTH 2

`define EIR_REG_RST 8'h00
`define EIR_IRQ_RST 2'h0
`define EIR_RESP_OKAY 2'h0
`define EIR_RESP_SLVERR 2'h2

`endif

// File: inc/eir_pkg.sv
// Types shared by the event router files.
// Assumes numeric constants come from the map header.
package eir_pkg;

    typedef enum logic [1:0]
    {
        EIR_WR_COLLECT = 2'h0,
        EIR_WR_EXEC = 2'h1,
        EIR_WR_RESP = 2'h3
    } eir_wr_state_type;

    typedef enum logic
    {
        EIR_RD_IDLE = 1'b0,
        EIR_RD_RESP = 1'b1
    } eir_rd_state_type;

endpackage

// File: rtl/eir_flag_bank.sv
// One bank of event flags that follow or latch their events.
// Assumes events synchronous to clk_sys_i and a one-cycle clear pulse.
`timescale 1ns/100ps

module eir_flag_bank #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] VALID_MASK = {WIDTH{1'b1}}
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic [WIDTH-1:0] event_i,
    input wire logic latch_mode_i,
    input wire logic clear_i,
    output logic [WIDTH-1:0] flags_o
);
    import eir_pkg::*;

    logic [WIDTH-1:0] flags_reg;
    logic [WIDTH-1:0] flags_next;

    initial
    begin
        if (WIDTH < 1)
        begin
            $error("eir_flag_bank: WIDTH must be at least one");
        end
    end

    // An event in the clearing cycle wins, so none slips past a read.
    for (genvar b = 0; b < WIDTH; b++)
    begin : g_bit
        always_comb
        begin
            if (!VALID_MASK[b])
            begin
                flags_next[b] = 1'b0;
            end
            else if (latch_mode_i)
            begin
                flags_next[b] = (flags_reg[b] & ~clear_i) | event_i[b];
            end
            else
            begin
                flags_next[b] = event_i[b];
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            flags_reg <= '0;
        end
        else
        begin
            flags_reg <= flags_next;
        end
    end

    assign flags_o = flags_reg;

endmodule // eir_flag_bank

// File: rtl/eir_top.sv
// Event router for the second interrupt pin, with its status and routing registers.
// Assumes synchronous level events and an AXI4-Lite master.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/100ps

module eir_top #(
    parameter int ADDR_W = 12
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic [15:0] sm_event_i,
    input wire logic [7:0] classifier_event_i,
    input wire logic long_counter_timeout_i,
    input wire logic significant_motion_i,
    input wire logic tilt_event_i,
    input wire logic step_detect_i,
    output logic second_interrupt_pin_o,
    output logic irq_o,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import eir_pkg::*;
    `include "eir_map.svh"

    initial
    begin
        if (ADDR_W < 10)
        begin
            $error("eir_top: ADDR_W must be at least 10");
        end
    end

    // Configuration registers.
    logic [7:0] sm_hi_pin2_route_reg;
    logic [7:0] sm_hi_pin2_route_next;
    logic [7:0] sm_lo_pin2_route_reg;
    logic [7:0] sm_lo_pin2_route_next;
    logic [7:0] classifier_pin2_route_reg;
    logic [7:0] classifier_pin2_route_next;
    logic embedded_latch_mode_reg;
    logic embedded_latch_mode_next;
    logic embedded_route_master_reg;
    logic embedded_route_master_next;
    logic [`EIR_IRQ_WIDTH-1:0] irq_status_reg;
    logic [`EIR_IRQ_WIDTH-1:0] irq_status_next;
    logic [`EIR_IRQ_WIDTH-1:0] irq_mask_reg;
    logic [`EIR_IRQ_WIDTH-1:0] irq_mask_next;
    logic pin_b_reg;
    logic pin_b_next;
    logic irq_reg;
    logic irq_next;

    // Bus state.
    eir_wr_state_type wr_state_reg;
    eir_wr_state_type wr_state_next;
    eir_rd_state_type rd_state_reg;
    eir_rd_state_type rd_state_next;
    logic aw_got_reg;
    logic aw_got_next;
    logic w_got_reg;
    logic w_got_next;
    logic [7:0] wr_idx_reg;
    logic [7:0] wr_idx_next;
    logic [7:0] wr_data_reg;
    logic [7:0] wr_data_next;
    logic wr_lane_reg;
    logic wr_lane_next;
    logic awready_reg;
    logic awready_next;
    logic wready_reg;
    logic wready_next;
    logic bvalid_reg;
    logic bvalid_next;
    logic [1:0] bresp_reg;
    logic [1:0] bresp_next;
    logic arready_reg;
    logic arready_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic [1:0] rresp_reg;
    logic [1:0] rresp_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    // Flags and clear pulses.
    logic [7:0] emb_event;
    logic [7:0] emb_flags;
    logic [7:0] sm_lo_flags;
    logic [7:0] sm_hi_flags;
    logic [7:0] cls_flags;
    logic clr_emb;
    logic clr_sm_lo;
    logic clr_sm_hi;
    logic clr_cls;
    logic ar_take;
    logic [7:0] rd_idx;
    logic wr_err_event;

    always_comb
    begin
        emb_event = 8'h00;
        emb_event[`EIR_EMB_LC_BIT] = long_counter_timeout_i;
        emb_event[`EIR_EMB_SIGMOT_BIT] = significant_motion_i;
        emb_event[`EIR_EMB_TILT_BIT] = tilt_event_i;
        emb_event[`EIR_EMB_STEP_BIT] = step_detect_i;
    end

    eir_flag_bank #(.WIDTH(8), .VALID_MASK(`EIR_EMB_VALID_MASK)) u_emb_flags (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .event_i(emb_event),
        .latch_mode_i(embedded_latch_mode_reg),
        .clear_i(clr_emb),
        .flags_o(emb_flags)
    );

    eir_flag_bank #(.WIDTH(8), .VALID_MASK(`EIR_ALL_VALID_MASK)) u_sm_lo_flags (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .event_i(sm_event_i[7:0]),
        .latch_mode_i(embedded_latch_mode_reg),
        .clear_i(clr_sm_lo),
        .flags_o(sm_lo_flags)
    );

    eir_flag_bank #(.WIDTH(8), .VALID_MASK(`EIR_ALL_VALID_MASK)) u_sm_hi_flags (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .event_i(sm_event_i[15:8]),
        .latch_mode_i(embedded_latch_mode_reg),
        .clear_i(clr_sm_hi),
        .flags_o(sm_hi_flags)
    );

    eir_flag_bank #(.WIDTH(8), .VALID_MASK(`EIR_ALL_VALID_MASK)) u_cls_flags (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .event_i(classifier_event_i),
        .latch_mode_i(embedded_latch_mode_reg),
        .clear_i(clr_cls),
        .flags_o(cls_flags)
    );

    // Read data is captured at the address edge, where a flag read also clears the flags in latched mode.
    assign ar_take = s_axi_arvalid & arready_reg;
    assign rd_idx = s_axi_araddr[9:2];

    always_comb
    begin
        rd_state_next = rd_state_reg;
        arready_next = arready_reg;
        rvalid_next = rvalid_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        clr_emb = 1'b0;
        clr_sm_lo = 1'b0;
        clr_sm_hi = 1'b0;
        clr_cls = 1'b0;
        case (rd_state_reg)
            EIR_RD_IDLE:
            begin
                if (ar_take)
                begin
                    rd_state_next = EIR_RD_RESP;
                    arready_next = 1'b0;
                    rvalid_next = 1'b1;
                    rresp_next = `EIR_RESP_OKAY;
                    rdata_next = 32'h0;
                    case (rd_idx)
                        `EIR_IDX_SM_HI_ROUTE: rdata_next[7:0] = sm_hi_pin2_route_reg;
                        `EIR_IDX_CLS_ROUTE: rdata_next[7:0] = classifier_pin2_route_reg;
                        `EIR_IDX_SM_LO_ROUTE: rdata_next[7:0] = sm_lo_pin2_route_reg;
                        `EIR_IDX_EMB_FLAGS:
                        begin
                            rdata_next[7:0] = emb_flags;
                            clr_emb = 1'b1;
                        end
                        `EIR_IDX_SM_LO_FLAGS:
                        begin
                            rdata_next[7:0] = sm_lo_flags;
                            clr_sm_lo = 1'b1;
                        end
                        `EIR_IDX_SM_HI_FLAGS:
                        begin
                            rdata_next[7:0] = sm_hi_flags;
                            clr_sm_hi = 1'b1;
                        end
                        `EIR_IDX_CLS_FLAGS:
                        begin
                            rdata_next[7:0] = cls_flags;
                            clr_cls = 1'b1;
                        end
                        `EIR_IDX_PAGE_CTRL: rdata_next[`EIR_LATCH_MODE_BIT] = embedded_latch_mode_reg;
                        `EIR_IDX_PIN_B_CFG: rdata_next[`EIR_ROUTE_MASTER_BIT] = embedded_route_master_reg;
                        `EIR_IDX_IRQ_STATUS: rdata_next[`EIR_IRQ_WIDTH-1:0] = irq_status_reg;
                        `EIR_IDX_IRQ_MASK: rdata_next[`EIR_IRQ_WIDTH-1:0] = irq_mask_reg;
                        default: rresp_next = `EIR_RESP_SLVERR;
                    endcase
                end
            end
            EIR_RD_RESP:
            begin
                if (s_axi_rready)
                begin
                    rd_state_next = EIR_RD_IDLE;
                    rvalid_next = 1'b0;
                    arready_next = 1'b1;
                end
            end
            default:
            begin
                rd_state_next = EIR_RD_IDLE;
                arready_next = 1'b1;
                rvalid_next = 1'b0;
            end
        endcase
    end

    // Address and data are taken in either order, then applied in one cycle.
    always_comb
    begin
        wr_state_next = wr_state_reg;
        aw_got_next = aw_got_reg;
        w_got_next = w_got_reg;
        wr_idx_next = wr_idx_reg;
        wr_data_next = wr_data_reg;
        wr_lane_next = wr_lane_reg;
        awready_next = awready_reg;
        wready_next = wready_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        sm_hi_pin2_route_next = sm_hi_pin2_route_reg;
        sm_lo_pin2_route_next = sm_lo_pin2_route_reg;
        classifier_pin2_route_next = classifier_pin2_route_reg;
        embedded_latch_mode_next = embedded_latch_mode_reg;
        embedded_route_master_next = embedded_route_master_reg;
        irq_mask_next = irq_mask_reg;
        wr_err_event = 1'b0;
        irq_status_next = irq_status_reg;
        case (wr_state_reg)
            EIR_WR_COLLECT:
            begin
                if (s_axi_awvalid && awready_reg)
                begin
                    aw_got_next = 1'b1;
                    wr_idx_next = s_axi_awaddr[9:2];
                end
                if (s_axi_wvalid && wready_reg)
                begin
                    w_got_next = 1'b1;
                    wr_data_next = s_axi_wdata[7:0];
                    wr_lane_next = s_axi_wstrb[0];
                end
                awready_next = ~aw_got_next;
                wready_next = ~w_got_next;
                if (aw_got_next && w_got_next)
                begin
                    wr_state_next = EIR_WR_EXEC;
                end
            end
            EIR_WR_EXEC:
            begin
                wr_state_next = EIR_WR_RESP;
                bvalid_next = 1'b1;
                bresp_next = `EIR_RESP_OKAY;
                case (wr_idx_reg)
                    `EIR_IDX_SM_HI_ROUTE:
                        if (wr_lane_reg) sm_hi_pin2_route_next = wr_data_reg;
                    `EIR_IDX_CLS_ROUTE:
                        if (wr_lane_reg) classifier_pin2_route_next = wr_data_reg;
                    `EIR_IDX_SM_LO_ROUTE:
                        if (wr_lane_reg) sm_lo_pin2_route_next = wr_data_reg;
                    `EIR_IDX_PAGE_CTRL:
                        if (wr_lane_reg) embedded_latch_mode_next = wr_data_reg[`EIR_LATCH_MODE_BIT];
                    `EIR_IDX_PIN_B_CFG:
                        if (wr_lane_reg) embedded_route_master_next = wr_data_reg[`EIR_ROUTE_MASTER_BIT];
                    `EIR_IDX_IRQ_MASK:
                        if (wr_lane_reg) irq_mask_next = wr_data_reg[`EIR_IRQ_WIDTH-1:0];
                    `EIR_IDX_IRQ_STATUS:
                        if (wr_lane_reg) irq_status_next = irq_status_reg & ~wr_data_reg[`EIR_IRQ_WIDTH-1:0];
                    // Flags are read-only; a write is ignored but acknowledged.
                    `EIR_IDX_EMB_FLAGS, `EIR_IDX_SM_LO_FLAGS, `EIR_IDX_SM_HI_FLAGS, `EIR_IDX_CLS_FLAGS:
                        bresp_next = `EIR_RESP_OKAY;
                    default:
                    begin
                        bresp_next = `EIR_RESP_SLVERR;
                        wr_err_event = 1'b1;
                    end
                endcase
            end
            EIR_WR_RESP:
            begin
                if (s_axi_bready)
                begin
                    wr_state_next = EIR_WR_COLLECT;
                    bvalid_next = 1'b0;
                    aw_got_next = 1'b0;
                    w_got_next = 1'b0;
                    awready_next = 1'b1;
                    wready_next = 1'b1;
                end
            end
            default:
            begin
                wr_state_next = EIR_WR_COLLECT;
                bvalid_next = 1'b0;
                aw_got_next = 1'b0;
                w_got_next = 1'b0;
                awready_next = 1'b1;
                wready_next = 1'b1;
            end
        endcase
        // Events are applied after the write-one clear, so a coincident event wins.
        irq_status_next[`EIR_IRQ_PIN_RISE_BIT] = irq_status_next[`EIR_IRQ_PIN_RISE_BIT] | (pin_b_next & ~pin_b_reg);
        irq_status_next[`EIR_IRQ_BUS_ERR_BIT] = irq_status_next[`EIR_IRQ_BUS_ERR_BIT] | wr_err_event;
    end

    // Built from flags, so in latched mode the pin holds until the flag is read.
    always_comb
    begin
        pin_b_next = embedded_route_master_reg &
            (|(sm_lo_flags & sm_lo_pin2_route_reg) |
             |(sm_hi_flags & sm_hi_pin2_route_reg) |
             |(cls_flags & classifier_pin2_route_reg));
        irq_next = |(irq_status_next & irq_mask_next);
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            wr_state_reg <= EIR_WR_COLLECT;
            rd_state_reg <= EIR_RD_IDLE;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            wr_idx_reg <= 8'h00;
            wr_data_reg <= 8'h00;
            wr_lane_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= `EIR_RESP_OKAY;
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rresp_reg <= `EIR_RESP_OKAY;
            rdata_reg <= 32'h0;
            sm_hi_pin2_route_reg <= `EIR_REG_RST;
            sm_lo_pin2_route_reg <= `EIR_REG_RST;
            classifier_pin2_route_reg <= `EIR_REG_RST;
            embedded_latch_mode_reg <= 1'b0;
            embedded_route_master_reg <= 1'b0;
            irq_status_reg <= `EIR_IRQ_RST;
            irq_mask_reg <= `EIR_IRQ_RST;
            pin_b_reg <= 1'b0;
            irq_reg <= 1'b0;
        end
        else
        begin
            wr_state_reg <= wr_state_next;
            rd_state_reg <= rd_state_next;
            aw_got_reg <= aw_got_next;
            w_got_reg <= w_got_next;
            wr_idx_reg <= wr_idx_next;
            wr_data_reg <= wr_data_next;
            wr_lane_reg <= wr_lane_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
            sm_hi_pin2_route_reg <= sm_hi_pin2_route_next;
            sm_lo_pin2_route_reg <= sm_lo_pin2_route_next;
            classifier_pin2_route_reg <= classifier_pin2_route_next;
            embedded_latch_mode_reg <= embedded_latch_mode_next;
            embedded_route_master_reg <= embedded_route_master_next;
            irq_status_reg <= irq_status_next;
            irq_mask_reg <= irq_mask_next;
            pin_b_reg <= pin_b_next;
            irq_reg <= irq_next;
        end
    end

    assign second_interrupt_pin_o = pin_b_reg;
    assign irq_o = irq_reg;
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;

endmodule // eir_top

// File: tb/eir_top_chk.sv
// Bus handshake and reset checker of the event router, bound to its top.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/100ps

module eir_top_chk (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic second_interrupt_pin_o,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);

    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    a_reset_quiet: assert property (
        $rose(resetn_i) |-> !second_interrupt_pin_o && !s_axi_bvalid && !s_axi_rvalid && s_axi_arready)
        else $error("outputs not idle after reset");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address ready while busy");
    a_aw_drop: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
        else $error("write address ready too soon");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
endmodule // eir_top_chk

// File: tb/eir_host.sv
// Host model: AXI4-Lite master with bounded waits, prompt or slow to answer.
// Assumes one task at a time; a timed-out wait raises stuck_o for good.
`timescale 1ns/100ps

module eir_host (
    input wire logic clk_sys_i,
    input wire logic slow_i,
    output logic stuck_o,
    output logic [11:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [11:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    initial
    begin
        {stuck_o, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    end

    // Released payload is inverted so a late sample cannot look valid.
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        logic done;
        @(posedge clk_sys_i);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'b11};
        s_axi_bready <= !slow_i;
        n = 0;
        do
        begin
            @(posedge clk_sys_i);
            n++;
            done = s_axi_bvalid && s_axi_bready;
            if (s_axi_awvalid && s_axi_awready)
                {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
            if (s_axi_wvalid && s_axi_wready)
                {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
            if (s_axi_bvalid)
                s_axi_bready <= !done;
        end
        while (!done && n < 40);
        r = s_axi_bresp;
        stuck_o <= stuck_o || !done;
    endtask

    // Read: the address is released once taken, then the data and response are sampled at the handshake.
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        logic done;
        @(posedge clk_sys_i);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 1'b1, !slow_i};
        n = 0;
        do
        begin
            @(posedge clk_sys_i);
            n++;
            done = s_axi_rvalid && s_axi_rready;
            if (s_axi_arvalid && s_axi_arready)
                {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
            if (s_axi_rvalid)
                s_axi_rready <= !done;
        end
        while (!done && n < 40);
        {d, r} = {s_axi_rdata, s_axi_rresp};
        stuck_o <= stuck_o || !done;
    endtask
endmodule // eir_host

// File: tb/tb.sv
// Bench: random routing and events, then latched, refused and interrupt cases.
// Assumes the host model runs every bus cycle; the checker is bound below.
`timescale 1ns/100ps
`include "eir_map.svh"

module tb;
    localparam logic [1:0] OK = `EIR_RESP_OKAY, ER = `EIR_RESP_SLVERR;
    localparam logic [11:0] HIR = 12'h040, CLR = 12'h044, EMB = 12'h048, SLO = 12'h04C, SHI = 12'h050;
    localparam logic [11:0] CLF = 12'h054, PGC = 12'h05C, CFG = 12'h17C, LOR = 12'h180, IST = 12'h184, IMK = 12'h188;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [15:0] sm_event_i = 16'h0000;
    logic [7:0] classifier_event_i = 8'h00;
    logic long_counter_timeout_i = 1'b0, significant_motion_i = 1'b0, tilt_event_i = 1'b0, step_detect_i = 1'b0;
    logic slow = 1'b0;
    logic second_interrupt_pin_o, irq_o, stuck;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int num_errors = 0;
    int check_count = 0;
    logic [31:0] seed;

    always #10 clk_sys_i = ~clk_sys_i;

    eir_top i_eir_top (.clk_sys_i, .resetn_i, .sm_event_i, .classifier_event_i, .long_counter_timeout_i,
        .significant_motion_i, .tilt_event_i, .step_detect_i, .second_interrupt_pin_o, .irq_o, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    eir_host u_host (.clk_sys_i, .slow_i(slow), .stuck_o(stuck), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        u_host.wr(a, d, r);
        check("write response", {30'h0, er}, {30'h0, r});
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        u_host.rd(a, d, r);
        check("read data", ed, d);
        check("read response", {30'h0, er}, {30'h0, r});
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clk_sys_i)
        if (stuck === 1'b1)
        begin
            num_errors++;
            report_and_stop();
        end

    initial
    begin
        logic [15:0] rt, es;
        logic [7:0] rc, ec;
        logic [3:0] ee;
        logic m;
        seed = $urandom(6);
        repeat (10) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        @(posedge clk_sys_i);
        rd(HIR, 32'h0, OK);
        rd(CLR, 32'h0, OK);
        rd(PGC, 32'h0, OK);
        wr(SLO, 32'hFF, OK);
        rd(SLO, 32'h0, OK);
        // Passes 0 and 1 route everything, master bit off then on.
        for (int k = 0; k < 12; k++)
        begin
            rt = (k < 2) ? 16'hFFFF : 16'($urandom);
            rc = (k < 2) ? 8'hFF : 8'($urandom);
            m = (k == 0) ? 1'b0 : (k == 1) ? 1'b1 : 1'($urandom);
            es = (k < 2) ? 16'hFFFF : 16'h0001 << ($urandom % 16);
            ec = (k < 2) ? 8'hFF : 8'h01 << ($urandom % 8);
            ee = 4'($urandom);
            slow <= k[0];
            wr(LOR, {24'h0, rt[7:0]}, OK);
            wr(HIR, {24'h0, rt[15:8]}, OK);
            wr(CLR, {24'h0, rc}, OK);
            wr(CFG, {30'h0, m, 1'b0}, OK);
            {sm_event_i, classifier_event_i} <= {es, ec};
            {long_counter_timeout_i, significant_motion_i, tilt_event_i, step_detect_i} <= ee;
            repeat (3) @(posedge clk_sys_i);
            check("pin", {31'h0, m && ((|(rt & es)) || (|(rc & ec)))}, {31'h0, second_interrupt_pin_o});
            rd(EMB, {24'h0, ee[3], 1'b0, ee[2:0], 3'h0}, OK);
            rd(SLO, {24'h0, es[7:0]}, OK);
            rd(SHI, {24'h0, es[15:8]}, OK);
            rd(CLF, {24'h0, ec}, OK);
            rd(HIR, {24'h0, rt[15:8]}, OK);
        end
        {sm_event_i, classifier_event_i} <= 24'h0;
        {long_counter_timeout_i, significant_motion_i, tilt_event_i, step_detect_i} <= 4'h0;
        wr(PGC, 32'h80, OK);
        rd(PGC, 32'h80, OK);
        wr(LOR, 32'h01, OK);
        wr(CFG, 32'h02, OK);
        wr(IST, 32'h3, OK);
        wr(IMK, 32'h1, OK);
        sm_event_i <= 16'h0001;
        @(posedge clk_sys_i);
        sm_event_i <= 16'h0000;
        repeat (4) @(posedge clk_sys_i);
        check("pin", 32'h1, {31'h0, second_interrupt_pin_o});
        check("irq", 32'h1, {31'h0, irq_o});
        rd(SLO, 32'h01, OK);
        rd(SLO, 32'h00, OK);
        check("pin", 32'h0, {31'h0, second_interrupt_pin_o});
        wr(IST, 32'h1, OK);
        wr(IMK, 32'h2, OK);
        wr(12'h3FC, 32'h1, ER);
        check("irq", 32'h1, {31'h0, irq_o});
        rd(IST, 32'h2, OK);
        rd(12'h3FC, 32'h0, ER);
        wr(IST, 32'h2, OK);
        check("irq", 32'h0, {31'h0, irq_o});
        report_and_stop();
    end
endmodule // tb

bind eir_top eir_top_chk u_chk (.clk_sys_i, .resetn_i, .second_interrupt_pin_o, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
